// >>> design/ssx_exec_unit.sv
// Purpose: stack and shift execution unit with an avalon-mm register port
// Assumes: master holds a request until waitrequest is low
// Notes:   stack memory is local; software loads it through a data window
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps

module ssx_exec_unit
  import ssx_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             execBusy
);

  // ==========================================================================
  // shift and rotate datapath
  // one function serves all four ops so carry and overflow rules stay in one place
  function automatic ssx_shift_s shiftOp(input ssx_op_e op, input logic byteMode,
                                         input logic [15:0] val, input logic cin);
    ssx_shift_s r;
    logic       msb;
    logic       inLeftRange;
    r = '0;
    msb = byteMode ? val[7] : val[15];
    inLeftRange = byteMode ? (val[7:0] >= OVF_BYTE_LO && val[7:0] < OVF_BYTE_HI)
                           : (val >= OVF_WORD_LO && val < OVF_WORD_HI);
    unique case (op)
      OP_SLA: begin
        r.value = byteMode ? {val[15:8], val[6:0], 1'b0} : {val[14:0], 1'b0};
        r.carry = msb;
        r.overflow = inLeftRange;
      end
      OP_RLC: begin
        r.value = byteMode ? {val[15:8], val[6:0], cin} : {val[14:0], cin};
        r.carry = msb;
        r.overflow = inLeftRange;
      end
      OP_SRA: begin
        r.value = byteMode ? {val[15:8], val[7], val[7:1]} : {val[15], val[15:1]};
        r.carry = val[0];
        r.overflow = 1'b0;
      end
      OP_RRC: begin
        r.value = byteMode ? {val[15:8], cin, val[7:1]} : {cin, val[15:1]};
        r.carry = val[0];
        r.overflow = ~msb & cin; // positive operand with carry set changes sign
      end
      default: begin
        r.value = val;
        r.carry = cin;
        r.overflow = 1'b0;
      end
    endcase
    return r;
  endfunction

  // ==========================================================================
  // state
  ssx_state_e  state;                  // sequencer state
  ssx_state_e  next_state;             // next sequencer state
  ssx_ctrl_s   ctrl;                   // latched command
  logic [15:0] operand;                // source / destination operand
  logic [15:0] stackPointer;           // stack_pointer
  logic [15:0] programCounter;         // program_counter
  logic [15:0] statusRegister;         // status_register
  logic [15:0] result;                 // destination value
  logic [15:0] temp;                   // word read from top_of_stack
  logic        phase;                  // second pop of an interrupt return
  logic [2:0]  waitCnt;                // remaining busy cycles of a nop
  logic [5:0]  memAddr;                // software window index
  logic        ackQ;                   // bus answer cycle
  logic [15:0] stackMem [STACK_WORDS]; // stack words, index is sp[6:1]

  // ==========================================================================
  // bus decode
  // one wait state on every access; accesses stall while an op runs
  wire         busReq     = avs_read | avs_write;
  wire         acc        = busReq & ~execBusy & ~ackQ;
  wire         writeTaken = avs_write & ackQ;
  wire         wrCtrl     = writeTaken && avs_address == OFS_CTRL;
  wire         wrOperand  = writeTaken && avs_address == OFS_OPERAND;
  wire         wrSp       = writeTaken && avs_address == OFS_STACKPTR;
  wire         wrPc       = writeTaken && avs_address == OFS_PROGCNT;
  wire         wrSr       = writeTaken && avs_address == OFS_STATUS;
  wire         wrMemAddr  = writeTaken && avs_address == OFS_MEMADDR;
  wire         wrMemData  = writeTaken && avs_address == OFS_MEMDATA;
  wire ssx_op_e opIn      = ssx_op_e'(avs_writedata[3:0]);
  wire         start      = wrCtrl && opIn != OP_NONE;
  wire [5:0]   spIdx      = stackPointer[6:1];

  // unmapped addresses read as zero and ignore writes
  wire [15:0]  next_readdata =
      (avs_address == OFS_CTRL)     ? {10'h000, ctrl} :
      (avs_address == OFS_OPERAND)  ? operand :
      (avs_address == OFS_STACKPTR) ? stackPointer :
      (avs_address == OFS_PROGCNT)  ? programCounter :
      (avs_address == OFS_STATUS)   ? statusRegister :
      (avs_address == OFS_RESULT)   ? result :
      (avs_address == OFS_BUSY)     ? {15'h0000, execBusy} :
      (avs_address == OFS_MEMADDR)  ? {10'h000, memAddr} :
      (avs_address == OFS_MEMDATA)  ? stackMem[memAddr] : 16'h0000;

  assign avs_waitrequest = busReq & ~ackQ;
  assign execBusy        = state != ST_IDLE;

  // ==========================================================================
  // execution datapath terms
  wire ssx_shift_s shiftOut = shiftOp(ctrl.op, ctrl.byteMode, operand, statusRegister[SR_C]);
  wire         isShift  = ctrl.op inside {OP_SLA, OP_RLC, OP_SRA, OP_RRC};
  wire         isPopLike = ctrl.op inside {OP_POP, OP_RET, OP_INTERRUPT_RETURN};
  // byte results to a register lose the high byte
  wire [15:0]  popValue = ctrl.byteMode ? {(ctrl.dstReg ? 8'h00 : operand[15:8]), temp[7:0]}
                                        : temp;
  wire [15:0]  shiftValue = (ctrl.byteMode && ctrl.dstReg) ? {8'h00, shiftOut.value[7:0]}
                                                           : shiftOut.value;
  wire         resNeg   = ctrl.byteMode ? shiftValue[7] : shiftValue[15];
  wire         resZero  = ctrl.byteMode ? shiftValue[7:0] == 8'h00 : shiftValue == 16'h0000;
  wire [15:0]  pushWord = ctrl.byteMode ? {stackMem[spIdx][15:8], operand[7:0]} : operand;

  // ==========================================================================
  // sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start) begin
          if (opIn inside {OP_POP, OP_RET, OP_INTERRUPT_RETURN}) begin
            next_state = ST_FETCH;
          end else if (opIn == OP_PUSH) begin
            next_state = ST_STEP;
          end else if (opIn inside {OP_SLA, OP_RLC, OP_SRA, OP_RRC}) begin
            next_state = ST_STORE;
          end else if (opIn inside {OP_NOP_REG, OP_NOP_JMP, OP_NOP_MEM}) begin
            next_state = ST_WAIT;
          end
        end
      end
      ST_FETCH: begin
        next_state = ST_STEP;
      end
      ST_STEP: begin
        if (ctrl.op == OP_PUSH || ctrl.op == OP_POP) begin
          next_state = ST_STORE;
        end else if (ctrl.op == OP_INTERRUPT_RETURN && !phase) begin
          next_state = ST_FETCH; // second pop brings the program_counter
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_STORE: begin
        next_state = ST_IDLE;
      end
      ST_WAIT: begin
        if (waitCnt == 3'd1) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE; // unused codes recover
      end
    endcase
  end

  // ==========================================================================
  // sequencer and bus answer registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      ackQ <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      state <= next_state;
      ackQ <= acc;
      if (acc) begin
        avs_readdata <= {16'h0000, next_readdata};
      end
    end
  end

  // ==========================================================================
  // command, operand and cycle counter
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= '0;
      operand <= 16'h0000;
      memAddr <= 6'h00;
      waitCnt <= 3'd0;
    end else begin
      if (wrCtrl) begin
        ctrl <= ssx_ctrl_s'(avs_writedata[5:0]);
      end
      if (wrOperand) begin
        operand <= avs_writedata[15:0];
      end
      if (wrMemAddr) begin
        memAddr <= avs_writedata[5:0];
      end
      // each nop substitute stays busy for its own cycle count
      if (start) begin
        waitCnt <= (opIn == OP_NOP_MEM) ? NOP_MEM_CYC :
                   (opIn == OP_NOP_JMP) ? NOP_JMP_CYC : NOP_REG_CYC;
      end else if (state == ST_WAIT) begin
        waitCnt <= waitCnt - 3'd1;
      end
    end
  end

  // ==========================================================================
  // stack pointer, program counter, temp and phase
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stackPointer <= SP_RESET;
      programCounter <= PC_RESET;
      temp <= 16'h0000;
      phase <= 1'b0;
    end else begin
      if (wrSp) begin
        stackPointer <= avs_writedata[15:0];
      end
      if (wrPc) begin
        programCounter <= avs_writedata[15:0];
      end
      if (start) begin
        phase <= 1'b0;
      end
      if (state == ST_FETCH) begin
        temp <= stackMem[spIdx]; // read before the pointer moves
      end
      if (state == ST_STEP) begin
        // step is two for either operand size, keeping words aligned
        if (ctrl.op == OP_PUSH) begin
          stackPointer <= stackPointer - STACK_STEP;
        end else begin
          stackPointer <= stackPointer + STACK_STEP;
        end
        if (ctrl.op == OP_RET || (ctrl.op == OP_INTERRUPT_RETURN && phase)) begin
          programCounter <= temp;
        end
        if (ctrl.op == OP_INTERRUPT_RETURN) begin
          phase <= ~phase;
        end
      end
    end
  end

  // ==========================================================================
  // status word and destination value
  // pop, push and return never touch the status word here
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      statusRegister <= SR_RESET;
      result <= 16'h0000;
    end else begin
      if (wrSr) begin
        statusRegister <= avs_writedata[15:0];
      end
      if (state == ST_STEP && ctrl.op == OP_INTERRUPT_RETURN && !phase) begin
        statusRegister <= temp; // flags and mode bits all restored
      end
      if (state == ST_STORE && ctrl.op == OP_POP) begin
        result <= popValue;
      end
      if (state == ST_STORE && isShift) begin
        result <= shiftValue;
        // only the four arithmetic flags change; mode bits hold
        statusRegister[SR_C] <= shiftOut.carry;
        statusRegister[SR_V] <= shiftOut.overflow;
        statusRegister[SR_N] <= resNeg;
        statusRegister[SR_Z] <= resZero;
      end
    end
  end

  // ==========================================================================
  // stack memory, no reset so it maps onto ram
  always_ff @(posedge clk_sys) begin
    if (state == ST_STORE && ctrl.op == OP_PUSH) begin
      stackMem[spIdx] <= pushWord; // written at the lowered pointer
    end else if (wrMemData) begin
      stackMem[memAddr] <= avs_writedata[15:0];
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence retiFirst;
    state == ST_STEP && ctrl.op == OP_INTERRUPT_RETURN && !phase;
  endsequence

  sequence retiSecond;
    state == ST_STEP && ctrl.op == OP_INTERRUPT_RETURN && phase;
  endsequence

  pop_sp_step_a: assert property (
    (state == ST_STEP && ctrl.op == OP_POP) |=> stackPointer == $past(stackPointer) + STACK_STEP
  ) else $error("pop did not advance the stack pointer by two");

  push_sp_step_a: assert property (
    (state == ST_STEP && ctrl.op == OP_PUSH) |=> stackPointer == $past(stackPointer) - STACK_STEP
  ) else $error("push did not lower the stack pointer by two");

  push_mem_a: assert property (
    (state == ST_STORE && ctrl.op == OP_PUSH && !ctrl.byteMode) |=> stackMem[$past(spIdx)] == $past(operand)
  ) else $error("push did not store the operand at the top of stack");

  byte_pop_high_a: assert property (
    (state == ST_STORE && ctrl.op == OP_POP && ctrl.byteMode && ctrl.dstReg) |=> result[15:8] == 8'h00
  ) else $error("byte pop into a register left a high byte");

  stack_flags_a: assert property (
    (state == ST_STEP && ctrl.op inside {OP_POP, OP_PUSH, OP_RET}) |=> $stable(statusRegister)
  ) else $error("stack operation changed the status word");

  ret_pc_load_a: assert property (
    (state == ST_STEP && ctrl.op == OP_RET) |=> programCounter == $past(temp) && state == ST_IDLE
  ) else $error("return did not load the program counter");

  interrupt_return_order_a: assert property (
    retiFirst |=> statusRegister == $past(temp) ##1 retiSecond
      ##1 (state == ST_IDLE && stackPointer == $past(stackPointer, 3) + STACK_STEP + STACK_STEP)
  ) else $error("interrupt return sequence out of order");

  word_left_ovf_a: assert property (
    (state == ST_STORE && ctrl.op inside {OP_SLA, OP_RLC} && !ctrl.byteMode)
      |=> statusRegister[SR_V] == ($past(operand) >= OVF_WORD_LO && $past(operand) < OVF_WORD_HI)
  ) else $error("word left shift overflow flag wrong");

  right_shift_v_a: assert property (
    (state == ST_STORE && ctrl.op == OP_SRA) |=> !statusRegister[SR_V] && statusRegister[SR_C] == $past(operand[0])
  ) else $error("arithmetic right shift flags wrong");

  shift_mode_a: assert property (
    (state == ST_STORE && isShift)
      |=> statusRegister[SR_OSCILLATOR_DISABLE:SR_GIE] == $past(statusRegister[SR_OSCILLATOR_DISABLE:SR_GIE])
  ) else $error("shift changed a mode bit");

  nop_mem_len_a: assert property (
    (state == ST_IDLE && start && opIn == OP_NOP_MEM) |=> (execBusy [*6]) ##1 !execBusy
  ) else $error("memory move substitute not six cycles");

endmodule

// >>> inc/ssx_pkg.sv
// Purpose: shared constants and types of the stack and shift execution unit
// Assumes: 32-bit avalon-mm slave, byte addresses, one register per aligned word
// Notes:   status word holds arithmetic flags and the three mode bits
package ssx_pkg;

  // ==========================================================================
  // register offsets (byte addresses)
  localparam logic [5:0] OFS_CTRL     = 6'h00; // command, starts an operation
  localparam logic [5:0] OFS_OPERAND  = 6'h04; // source / destination operand
  localparam logic [5:0] OFS_STACKPTR = 6'h08; // stack_pointer
  localparam logic [5:0] OFS_PROGCNT  = 6'h0C; // program_counter
  localparam logic [5:0] OFS_STATUS   = 6'h10; // status_register
  localparam logic [5:0] OFS_RESULT   = 6'h14; // destination value, read only
  localparam logic [5:0] OFS_BUSY     = 6'h18; // bit 0 busy, read only
  localparam logic [5:0] OFS_MEMADDR  = 6'h1C; // stack memory word index
  localparam logic [5:0] OFS_MEMDATA  = 6'h20; // stack memory data window

  // ==========================================================================
  // field positions
  localparam int CTRL_BYTE_BIT   = 4;  // byte form of the operation
  localparam int CTRL_DSTREG_BIT = 5;  // destination is a register
  localparam int SR_C            = 0;  // carry
  localparam int SR_Z            = 1;  // zero
  localparam int SR_N            = 2;  // negative
  localparam int SR_GIE          = 3;  // global_irq_enable
  localparam int SR_PROCESSOR_HALT       = 4;  // processor_halt
  localparam int SR_OSCILLATOR_DISABLE       = 5;  // oscillator_disable
  localparam int SR_V            = 8;  // overflow

  // ==========================================================================
  // reset values and constants
  localparam logic [15:0] SP_RESET    = 16'h0080;
  localparam logic [15:0] PC_RESET    = 16'h0000;
  localparam logic [15:0] SR_RESET    = 16'h0000;
  localparam logic [15:0] STACK_STEP  = 16'h0002;
  localparam logic [15:0] OVF_WORD_LO = 16'h4000;
  localparam logic [15:0] OVF_WORD_HI = 16'hC000;
  localparam logic [7:0]  OVF_BYTE_LO = 8'h40;
  localparam logic [7:0]  OVF_BYTE_HI = 8'hC0;
  localparam int          STACK_WORDS = 64;
  localparam logic [2:0]  NOP_REG_CYC = 3'd1; // register move of immediate zero
  localparam logic [2:0]  NOP_JMP_CYC = 3'd2; // relative jump to next word
  localparam logic [2:0]  NOP_MEM_CYC = 3'd6; // indexed to indexed memory move

  // ==========================================================================
  // types
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_POP = 4'h1, OP_PUSH = 4'h2, OP_RET = 4'h3,
    OP_INTERRUPT_RETURN = 4'h4, OP_SLA = 4'h5, OP_RLC = 4'h6, OP_SRA = 4'h7,
    OP_RRC  = 4'h8, OP_NOP_REG = 4'h9, OP_NOP_JMP = 4'hA, OP_NOP_MEM = 4'hB
  } ssx_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_FETCH = 3'b001, ST_STEP = 3'b011,
    ST_STORE = 3'b010, ST_WAIT = 3'b110
  } ssx_state_e;

  typedef struct packed {
    logic    dstReg;   // destination is a register
    logic    byteMode; // byte form
    ssx_op_e op;       // operation
  } ssx_ctrl_s;

  typedef struct packed {
    logic [15:0] value;    // shifted operand
    logic        carry;    // new carry
    logic        overflow; // new overflow
  } ssx_shift_s;

endpackage

// >>> verification/tb_top.sv
// Purpose: self-checking bench of the stack and shift execution unit
// Assumes: register map, op codes and status bit positions of ssx_pkg
// Notes:   shift cases are random from a fixed seed, with corner values first
`timescale 1ns/100ps

module tb_top
  import ssx_pkg::*;
;
  // ==========================================================================
  // signals
  logic        clk_sys;                 // 125 MHz bench clock
  logic        reset_n;                 // async reset, active low
  logic [5:0]  avs_address;             // bus address
  logic        avs_read;                // read request
  logic        avs_write;               // write request
  logic [31:0] avs_writedata;           // write data
  logic [31:0] avs_readdata;            // read data
  logic        avs_waitrequest;         // slave stall
  logic        execBusy;                // operation running
  int          failures = 0;            // mismatches seen
  int          nTests   = 0;            // comparisons made
  int          cycles   = 0;            // hang guard
  integer      seed     = 25649;        // fixed seed, repeatable run
  logic [15:0] corner [9] = '{16'h4000, 16'hBFFF, 16'h3FFF, 16'hC000,
                              16'hFF40, 16'h00BF, 16'h803F, 16'h00C0, 16'h8000};
  logic [3:0]  nopOp [5]  = '{OP_NOP_REG, OP_NOP_JMP, OP_NOP_MEM, OP_NONE, 4'hC};
  int          nopCyc [5] = '{1, 2, 6, 0, 0};

  // clock, half period 4 ns
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  ssx_exec_unit dut (
    .clk_sys         (clk_sys),
    .reset_n         (reset_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .execBusy        (execBusy)
  );

  // hang guard: whole run needs well under this many cycles
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 8000) begin
      failures = failures + 1;
      test_done();
    end
  end

  // ==========================================================================
  // tasks
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // exact compare of a register value, mask applied by the caller
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // compare of a busy length counted by the bench
  task automatic chkCyc(input string what, input int exp, input int got);
    nTests++;
    if (got != exp) begin
      failures++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // one avalon access; request held until waitrequest is seen low
  // no own wait limit: a stuck slave is caught by the hang guard
  task automatic avBus(input logic wr, input logic [5:0] addr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    avs_address   <= addr;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wrR(input logic [5:0] addr, input logic [15:0] v);
    logic [31:0] rd;
    avBus(1'b1, addr, {16'h0000, v}, rd);
  endtask

  // read a register and compare the bits under mask, upper half must be zero
  task automatic rdChk(input string what, input logic [5:0] addr, input logic [15:0] exp, input logic [15:0] m);
    logic [31:0] rd;
    avBus(1'b0, addr, 32'h0000_0000, rd);
    chk(what, {16'h0000, exp & m}, rd & {16'hFFFF, m});
  endtask

  task automatic memWr(input logic [15:0] idx, input logic [15:0] v);
    wrR(OFS_MEMADDR, idx);
    wrR(OFS_MEMDATA, v);
  endtask

  task automatic memChk(input string what, input logic [15:0] idx, input logic [15:0] exp);
    wrR(OFS_MEMADDR, idx);
    rdChk(what, OFS_MEMDATA, exp, 16'hFFFF);
  endtask

  // start an op, count the cycles busy stays high (sampled mid cycle)
  task automatic runOp(input logic [3:0] op, input logic bm, input logic dr, output int cyc);
    logic [31:0] rd;
    avBus(1'b1, OFS_CTRL, {26'h000_0000, dr, bm, op}, rd);
    cyc = 0;
    @(negedge clk_sys);
    while (execBusy === 1'b1 && cyc < 20) begin
      cyc++;
      @(negedge clk_sys);
    end
  endtask

  // expected {status, result} of a shift or rotate
  function automatic logic [31:0] shiftRef(input logic [3:0] op, input logic bm, input logic dr,
                                           input logic [15:0] a, input logic [15:0] s);
    logic [15:0] m;  // msb of the operand width
    logic [15:0] w;  // width mask
    logic [15:0] x;  // operand inside the width
    logic [15:0] r;  // shifted value
    logic        v;  // new overflow
    m = bm ? 16'h0080 : 16'h8000;
    w = bm ? 16'h00FF : 16'hFFFF;
    x = a & w;
    v = bm ? (x[7:0] >= OVF_BYTE_LO && x[7:0] < OVF_BYTE_HI) : (x >= OVF_WORD_LO && x < OVF_WORD_HI);
    case (op)
      OP_SLA:  r = (x << 1) & w;
      OP_RLC:  r = ((x << 1) & w) | {15'h0000, s[SR_C]};
      OP_SRA:  r = (x >> 1) | (x & m);
      default: r = (x >> 1) | (s[SR_C] ? m : 16'h0000);
    endcase
    if (op == OP_SRA) v = 1'b0;
    if (op == OP_RRC) v = ~|(x & m) & s[SR_C];
    s[SR_C] = (op == OP_SLA || op == OP_RLC) ? |(x & m) : x[0];
    s[SR_Z] = ((r & w) == 16'h0000);
    s[SR_N] = |(r & m);
    s[SR_V] = v;
    // memory destination keeps the operand high byte
    if (bm && !dr) r = r | (a & 16'hFF00);
    return {s, r};
  endfunction

  // ==========================================================================
  // main sequence
  initial begin
    logic [15:0] a;    // operand
    logic [15:0] st;   // status word
    logic [15:0] pcv;  // return address
    logic [31:0] e;    // expected status and result
    logic [3:0]  op;   // shift op under test
    int          cyc;  // busy cycles
    reset_n       = 1'b0;
    avs_address   = 6'h00;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    rdChk("reset sp", OFS_STACKPTR, SP_RESET, 16'hFFFF);
    rdChk("reset pc", OFS_PROGCNT, PC_RESET, 16'hFFFF);
    rdChk("reset status", OFS_STATUS, SR_RESET, 16'hFFFF);
    rdChk("unmapped", 6'h3C, 16'h0000, 16'hFFFF);
    $display("test reset done");
    // push, byte push, pop, byte pop, return chained on one stack
    a   = 16'($random(seed));
    pcv = 16'($random(seed));
    wrR(OFS_STATUS, 16'h013F);
    wrR(OFS_STACKPTR, 16'h0042);
    wrR(OFS_OPERAND, a);
    memWr(16'h001F, 16'hA5A5);
    memWr(16'h0021, pcv);
    runOp(OP_PUSH, 1'b0, 1'b1, cyc);
    rdChk("push sp", OFS_STACKPTR, 16'h0040, 16'hFFFF); // sp lowered first
    memChk("push word", 16'h0020, a); // word lands at new top
    runOp(OP_PUSH, 1'b1, 1'b1, cyc);
    rdChk("byte push sp", OFS_STACKPTR, 16'h003E, 16'hFFFF); // byte step is two
    memChk("byte push", 16'h001F, {8'hA5, a[7:0]}); // low byte at new top
    runOp(OP_POP, 1'b0, 1'b1, cyc);
    rdChk("pop result", OFS_RESULT, {8'hA5, a[7:0]}, 16'hFFFF); // top word read
    rdChk("pop sp", OFS_STACKPTR, 16'h0040, 16'hFFFF); // sp raised
    runOp(OP_POP, 1'b1, 1'b1, cyc);
    rdChk("byte pop result", OFS_RESULT, {8'h00, a[7:0]}, 16'hFFFF); // high byte zero
    rdChk("byte pop sp", OFS_STACKPTR, 16'h0042, 16'hFFFF); // byte step is two
    runOp(OP_RET, 1'b0, 1'b0, cyc);
    rdChk("return pc", OFS_PROGCNT, pcv, 16'hFFFF); // pc from top
    rdChk("return sp", OFS_STACKPTR, 16'h0044, 16'hFFFF); // sp raised
    rdChk("stack status", OFS_STATUS, 16'h013F, 16'h013F); // flags and mode kept
    $display("test stack done");
    // interrupt return, each bit flipped against the old status
    for (int i = 0; i < 3; i++) begin
      st  = 16'($random(seed)) & 16'h013F;
      pcv = 16'($random(seed));
      wrR(OFS_STATUS, ~st & 16'h013F);
      wrR(OFS_STACKPTR, 16'h0040);
      memWr(16'h0020, st);
      memWr(16'h0021, pcv);
      runOp(OP_INTERRUPT_RETURN, 1'b0, 1'b0, cyc);
      rdChk("interrupt_return status", OFS_STATUS, st, 16'h013F); // status popped
      rdChk("interrupt_return pc", OFS_PROGCNT, pcv, 16'hFFFF); // pc from second word
      rdChk("interrupt_return sp", OFS_STACKPTR, 16'h0044, 16'hFFFF); // two steps of two
    end
    $display("test interrupt return done");
    // shifts: op cycles fastest, width every fourth, corners then random
    for (int i = 0; i < 40; i++) begin
      op = 4'(5 + i % 4);
      a  = (i < 9) ? corner[i] : 16'($random(seed));
      st = 16'($random(seed)) & 16'h013F;
      e  = shiftRef(op, i[2], i[3], a, st);
      wrR(OFS_OPERAND, a);
      wrR(OFS_STATUS, st);
      runOp(op, i[2], i[3], cyc);
      rdChk("shift result", OFS_RESULT, e[15:0], 16'hFFFF); // value
      rdChk("shift status", OFS_STATUS, e[31:16], 16'h013F); // flags
    end
    $display("test shifts done");
    // substitute ops and codes that start nothing
    for (int i = 0; i < 5; i++) begin
      runOp(nopOp[i], 1'b0, 1'b0, cyc);
      chkCyc("busy cycles", nopCyc[i], cyc); // busy length
    end
    $display("test timing done");
    test_done();
  end
endmodule
